// ==== src/sideband_consts.svh ====
// Offsets, field positions, reset values and timing counts of the side-band block
`ifndef SIDEBAND_CONSTS_SVH
`define SIDEBAND_CONSTS_SVH
`define ADDR_WRAP_BIT        20
`define LOW_REGION_SIZE      32'h0001_0000
`define MEG_BASE             32'h0010_0000
`define COPRO_CTRL_PORT      32'h8000_00f8
`define COPRO_OPND_PORT      32'h8000_00fc
`define MGMT_DRIVE_DELAY     3'h4
`define MGMT_RELEASE_EDGES   3'h2
`define MGMT_MIN_LOW         3'h4
`define PHASE_RESET          1'h0
`define SYNC_RESET           7'h4d
`define COPRO_RESET          3'h6
`endif

// ==== src/sideband_pkg.sv ====
// Types shared by the side-band control block
package sideband_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_FIRST = 2'b01,
    BUS_BUSY  = 2'b10,
    BUS_HOLD  = 2'b11
  } bus_state_e;

  typedef enum logic [1:0] {
    MGMT_OFF     = 2'b00,
    MGMT_WAIT    = 2'b01,
    MGMT_ACTIVE  = 2'b10,
    MGMT_RELEASE = 2'b11
  } mgmt_state_e;

  typedef struct packed {
    logic        wrap_mask_enable_bit;
    logic        low_region_nocache_bit;
    logic        paging_on;
  } core_config_s;

  typedef struct packed {
    logic        busy_b;
    logic        error_b;
    logic        copro_operand_req;
  } copro_in_s;
endpackage : sideband_pkg

// ==== src/cpu_sideband_control.sv ====
// Side-band control: address wrap, hold, coprocessor, management interrupt
`timescale 1ns/10ps
`include "sideband_consts.svh"
module cpu_sideband_control #(
  parameter int ADDR_W = 32
) (
  input  wire logic                      clock,             // Double-rate clock
  input  wire logic                      rst_b,             // Async reset, active low
  input  wire sideband_pkg::core_config_s cfg,              // Configuration bits
  input  wire logic                      wrap_mask_in_b,    // Wrap-mask pin, active low
  input  wire logic                      hold_req,          // Hold request pin
  input  wire logic                      nmi_in,            // Non-maskable interrupt pin
  input  wire logic                      lock_active,       // Locked sequence running
  input  wire logic                      bus_req,           // Internal bus request
  input  wire logic                      cycle_done,        // Current bus cycle ends
  input  wire logic                      access_strobe,     // Cache or bus access start
  input  wire logic [ADDR_W-1:0]         core_addr,         // Address from core
  input  wire logic                      io_cycle,          // Access is I/O
  input  wire logic                      mem_cycle,         // Access is memory
  input  wire sideband_pkg::copro_in_s   copro_in,          // Coprocessor pins, async
  input  wire logic                      mgmt_interrupt_i,  // Management pin input level
  input  wire logic                      mgmt_return_instr, // Return instruction retired
  input  wire logic                      io_instr_done,     // I/O instruction completes
  input  wire logic                      suspend_req_b,     // Suspend request pin
  input  wire logic                      suspend_state,     // Core is suspended
  output logic [ADDR_W-1:0]              out_addr,          // Masked address
  output logic                           cacheable,         // Access may be cached
  output logic                           hold_grant,        // Hold acknowledge
  output logic                           bus_float,         // Float bus pins
  output logic                           suspend_ack_b,     // Suspend acknowledge
  output logic                           nmi_pending,       // Latched interrupt 2
  output logic                           copro_ctrl_sel,    // Opcode port access
  output logic                           copro_opnd_sel,    // Operand port access
  output sideband_pkg::copro_in_s        copro_sampled,     // Sampled coprocessor pins
  output logic                           mgmt_interrupt_o,  // Management pin drive level
  output logic                           mgmt_interrupt_oe_b, // Management drive enable
  output logic                           mgmt_mode,         // In management mode
  output logic                           mgmt_enter,        // Pulse: enter handler
  output logic                           mgmt_addr_strobe_b, // Management address strobe
  output logic                           addr_strobe_b,     // Normal address strobe
  output logic [1:0]                     bus_state          // Bus state
);
  // Pin synchronisers: first stage read only by second
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  wire  [6:0] pins = {wrap_mask_in_b, hold_req, nmi_in, copro_in, mgmt_interrupt_i};
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= `SYNC_RESET; // Idle pin levels, so no false edge after reset
      sync2_reg <= `SYNC_RESET;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end
  wire wrap_s_b = sync2_reg[6];
  wire hold_s   = sync2_reg[5];
  wire nmi_s    = sync2_reg[4];
  wire mgmt_s_b = sync2_reg[0];

  // Internal processor clock phase: 1 = phase one begins
  logic phase_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) phase_reg <= `PHASE_RESET;
    else phase_reg <= ~phase_reg;
  end
  wire ph1_edge = phase_reg;
  wire ph2_edge = ~phase_reg;

  // Address wrap masking
  logic wrap_seen_reg, wrap_apply_reg;
  wire  wrap_req = cfg.wrap_mask_enable_bit & ~cfg.paging_on & ~wrap_s_b;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) wrap_seen_reg <= 1'b0;
    else if (ph2_edge) wrap_seen_reg <= wrap_req;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) wrap_apply_reg <= 1'b0;
    else if (access_strobe) wrap_apply_reg <= wrap_seen_reg;
  end
  wire mask_now = (access_strobe ? wrap_seen_reg : wrap_apply_reg) & ~cfg.paging_on;
  always_comb begin
    out_addr = core_addr;
    out_addr[`ADDR_WRAP_BIT] = core_addr[`ADDR_WRAP_BIT] & ~mask_now;
  end
  wire in_low = core_addr < `LOW_REGION_SIZE;
  wire in_meg = (core_addr >= `MEG_BASE) && (core_addr < `MEG_BASE + `LOW_REGION_SIZE);
  assign cacheable = mem_cycle & ~(cfg.low_region_nocache_bit & (in_low | in_meg));

  // Coprocessor ports and inputs
  wire copro_port = io_cycle & (core_addr == `COPRO_CTRL_PORT || core_addr == `COPRO_OPND_PORT);
  assign copro_ctrl_sel = io_cycle & (core_addr == `COPRO_CTRL_PORT);
  assign copro_opnd_sel = io_cycle & (core_addr == `COPRO_OPND_PORT);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) copro_sampled <= `COPRO_RESET;
    else if (ph1_edge) copro_sampled <= sync2_reg[3:1];
  end

  // Hold / bus state machine
  sideband_pkg::bus_state_e bs_reg, bs_next;
  logic hold_smp_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) hold_smp_reg <= 1'b0;
    else if (ph1_edge) hold_smp_reg <= hold_s;
  end
  always_comb begin
    bs_next = bs_reg;
    unique case (bs_reg)
      sideband_pkg::BUS_IDLE:
        if (hold_smp_reg) bs_next = sideband_pkg::BUS_HOLD;
        else if (bus_req) bs_next = sideband_pkg::BUS_FIRST;
      sideband_pkg::BUS_FIRST: bs_next = sideband_pkg::BUS_BUSY;
      sideband_pkg::BUS_BUSY:
        if (cycle_done) begin
          if (hold_smp_reg && !lock_active) bs_next = sideband_pkg::BUS_HOLD;
          else if (bus_req) bs_next = sideband_pkg::BUS_FIRST;
          else bs_next = sideband_pkg::BUS_IDLE;
        end
      sideband_pkg::BUS_HOLD:
        if (!hold_smp_reg)
          bs_next = bus_req ? sideband_pkg::BUS_FIRST : sideband_pkg::BUS_IDLE;
    endcase
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) bs_reg <= sideband_pkg::BUS_IDLE;
    else bs_reg <= bs_next;
  end
  wire in_hold = bs_reg == sideband_pkg::BUS_HOLD;
  assign bus_state  = bs_reg;
  assign hold_grant = in_hold;
  assign bus_float  = in_hold;
  assign suspend_ack_b = ~(~suspend_req_b & suspend_state);
  wire strobe = bs_reg == sideband_pkg::BUS_FIRST;
  assign addr_strobe_b      = ~(strobe & ~(mgmt_mode & mem_cycle));
  assign mgmt_addr_strobe_b = ~(strobe & mgmt_mode & mem_cycle);

  // Interrupt 2 edge latch
  logic nmi_d_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      nmi_d_reg   <= 1'b0;
      nmi_pending <= 1'b0;
    end else begin
      nmi_d_reg <= nmi_s;
      if (nmi_s & ~nmi_d_reg) nmi_pending <= 1'b1;
      else if (!in_hold && !mgmt_mode) nmi_pending <= 1'b0; // Serviced; lower than mgmt
    end
  end

  // Management interrupt handshake
  sideband_pkg::mgmt_state_e ms_reg, ms_next;
  logic [2:0] mcnt_reg, mcnt_next;
  logic       trap_reg;
  wire        mgmt_seen = ph1_edge & ~mgmt_s_b & ~in_hold;
  always_comb begin
    ms_next = ms_reg;
    mcnt_next = mcnt_reg;
    unique case (ms_reg)
      sideband_pkg::MGMT_OFF:
        if (mgmt_seen) begin
          ms_next = sideband_pkg::MGMT_WAIT;
          mcnt_next = 3'h1;
        end
      sideband_pkg::MGMT_WAIT: begin
        mcnt_next = mcnt_reg + 3'h1;
        if (mcnt_reg == `MGMT_DRIVE_DELAY - 3'h1) ms_next = sideband_pkg::MGMT_ACTIVE;
      end
      sideband_pkg::MGMT_ACTIVE:
        if (mgmt_return_instr) begin
          ms_next = sideband_pkg::MGMT_RELEASE;
          mcnt_next = 3'h0;
        end
      sideband_pkg::MGMT_RELEASE: begin
        mcnt_next = mcnt_reg + 3'h1;
        if (mcnt_reg == `MGMT_RELEASE_EDGES - 3'h1) ms_next = sideband_pkg::MGMT_OFF;
      end
    endcase
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ms_reg   <= sideband_pkg::MGMT_OFF;
      mcnt_reg <= 3'h0;
    end else begin
      ms_reg   <= ms_next;
      mcnt_reg <= mcnt_next;
    end
  end
  assign mgmt_interrupt_oe_b = ~(ms_reg == sideband_pkg::MGMT_ACTIVE ||
                                 ms_reg == sideband_pkg::MGMT_RELEASE);
  assign mgmt_interrupt_o = ms_reg == sideband_pkg::MGMT_RELEASE;
  assign mgmt_mode = ms_reg == sideband_pkg::MGMT_ACTIVE;

  // Trap: request arriving during a non-coprocessor I/O cycle
  wire trap_set = io_cycle & ~copro_port & (ms_reg != sideband_pkg::MGMT_OFF);
  // A request landing in the done cycle is honoured by the enter pulse, never lost
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) trap_reg <= 1'b0;
    else trap_reg <= (trap_reg | trap_set) & ~io_instr_done;
  end
  assign mgmt_enter = (ms_next == sideband_pkg::MGMT_ACTIVE && ms_reg == sideband_pkg::MGMT_WAIT)
                      | ((trap_reg | trap_set) & io_instr_done);

  property p_hold_grant;
    @(posedge clock) disable iff (!rst_b)
      in_hold |-> hold_grant && bus_float && addr_strobe_b && mgmt_addr_strobe_b;
  endproperty
  a_hold_grant: assert property (p_hold_grant) else $error("grant or float wrong");
  property p_hold_lock;
    @(posedge clock) disable iff (!rst_b)
      (bs_reg == sideband_pkg::BUS_BUSY && lock_active) |=> !in_hold;
  endproperty
  a_hold_lock: assert property (p_hold_lock) else $error("hold during lock");
  property p_hold_exit;
    @(posedge clock) disable iff (!rst_b)
      (in_hold && !hold_smp_reg && bus_req) |=> bs_reg == sideband_pkg::BUS_FIRST;
  endproperty
  a_hold_exit: assert property (p_hold_exit) else $error("bad hold exit");
  property p_wrap;
    @(posedge clock) disable iff (!rst_b) cfg.paging_on |-> out_addr == core_addr;
  endproperty
  a_wrap: assert property (p_wrap) else $error("masked with paging");
  property p_mask;
    @(posedge clock) disable iff (!rst_b) mask_now |-> !out_addr[`ADDR_WRAP_BIT];
  endproperty
  a_mask: assert property (p_mask) else $error("bit 20 not masked");
  property p_drive_low;
    @(posedge clock) disable iff (!rst_b)
      (ms_reg == sideband_pkg::MGMT_OFF && mgmt_seen) |->
        ##3 mgmt_interrupt_oe_b ##1 (!mgmt_interrupt_oe_b && !mgmt_interrupt_o);
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("mgmt drive late");
  property p_release;
    @(posedge clock) disable iff (!rst_b)
      (mgmt_mode && mgmt_return_instr) |=> (mgmt_interrupt_o && !mgmt_interrupt_oe_b) [*2] ##1 mgmt_interrupt_oe_b;
  endproperty
  a_release: assert property (p_release) else $error("mgmt release wrong");
  property p_nmi;
    @(posedge clock) disable iff (!rst_b) (in_hold && nmi_s && !nmi_d_reg) |=> nmi_pending;
  endproperty
  a_nmi: assert property (p_nmi) else $error("interrupt 2 lost");
  property p_strobe;
    @(posedge clock) disable iff (!rst_b) !(mgmt_addr_strobe_b == 1'b0 && addr_strobe_b == 1'b0);
  endproperty
  a_strobe: assert property (p_strobe) else $error("both strobes");
  property p_wrap_sample;
    @(posedge clock) disable iff (!rst_b)
      ph1_edge |=> $stable(wrap_seen_reg);
  endproperty
  a_wrap_sample: assert property (p_wrap_sample) else $error("wrap sampled off phase two");
  property p_apply_hold;
    @(posedge clock) disable iff (!rst_b)
      !access_strobe |=> $stable(wrap_apply_reg);
  endproperty
  a_apply_hold: assert property (p_apply_hold) else $error("mask moved between accesses");
  property p_hold_sample;
    @(posedge clock) disable iff (!rst_b)
      !ph1_edge |=> $stable(hold_smp_reg);
  endproperty
  a_hold_sample: assert property (p_hold_sample) else $error("hold sampled off phase one");
  property p_copro_sample;
    @(posedge clock) disable iff (!rst_b)
      !ph1_edge |=> $stable(copro_sampled);
  endproperty
  a_copro_sample: assert property (p_copro_sample) else $error("coprocessor sample off phase");
  property p_trap_done;
    @(posedge clock) disable iff (!rst_b)
      io_instr_done |=> !trap_reg;
  endproperty
  a_trap_done: assert property (p_trap_done) else $error("trap left pending");
  property p_mgmt_hold;
    @(posedge clock) disable iff (!rst_b)
      (in_hold && ms_reg == sideband_pkg::MGMT_OFF) |=> ms_reg == sideband_pkg::MGMT_OFF;
  endproperty
  a_mgmt_hold: assert property (p_mgmt_hold) else $error("management taken in hold");
  c_hold: cover property (@(posedge clock) disable iff (!rst_b) in_hold ##1 !in_hold);
  c_trap: cover property (@(posedge clock) disable iff (!rst_b) trap_reg && io_instr_done);
  c_lock: cover property (@(posedge clock) disable iff (!rst_b)
    bs_reg == sideband_pkg::BUS_BUSY && lock_active && hold_smp_reg);
  c_mgmt: cover property (@(posedge clock) disable iff (!rst_b) mgmt_mode ##1 mgmt_return_instr);
  c_wrap: cover property (@(posedge clock) disable iff (!rst_b) mask_now && access_strobe);
endmodule : cpu_sideband_control

// ==== verif/chipset_model.sv ====
// Chipset-side model: hold, wrap mask and management line drivers
`timescale 1ns/10ps
module chipset_model (
  input  wire logic clock,     // Double-rate clock
  input  wire logic want_hold, // Bench asks for the bus
  input  wire logic want_wrap, // Bench asks for masking
  input  wire logic want_mgmt, // Bench asks for a management interrupt
  input  wire logic mgmt_o,    // Device drive level
  input  wire logic mgmt_oe_b, // Device drive enable, low = driving
  output logic      hold_req,  // Hold request pin
  output logic      wrap_b,    // Wrap-mask pin, active low
  output wire logic mgmt_line  // Resolved management line
);
  logic pull_low;

  initial begin
    hold_req = 1'b0;
    wrap_b   = 1'b1;
    pull_low = 1'b0;
  end

  // Whole-cycle levels only, so every request spans at least one full period
  always @(posedge clock) begin
    hold_req <= want_hold;
    wrap_b   <= ~want_wrap;
    pull_low <= want_mgmt;
  end

  // Pull-up returns the line high once nobody drives it
  assign mgmt_line = !mgmt_oe_b ? mgmt_o : (pull_low ? 1'b0 : 1'b1);
endmodule : chipset_model

// ==== verif/cpu_sideband_control_test.sv ====
// Self-checking bench of the side-band control block
`timescale 1ns/10ps
module cpu_sideband_control_test;
  logic clock = 1'b0, rst_b = 1'b0, nmi_in = 1'b0, lock_active = 1'b0, bus_req = 1'b0;
  logic cycle_done = 1'b0, access_strobe = 1'b0, io_cycle = 1'b0, mem_cycle = 1'b0;
  logic mgmt_return_instr = 1'b0, io_instr_done = 1'b0, suspend_req_b = 1'b1;
  logic suspend_state = 1'b0, want_hold = 1'b0, want_wrap = 1'b0, want_mgmt = 1'b0;
  logic [31:0] core_addr = 32'h0;
  sideband_pkg::core_config_s cfg = '0;
  sideband_pkg::copro_in_s copro_in = 3'h7, copro_sampled;
  logic hold_req, wrap_b, mgmt_line, hold_grant, bus_float, nmi_pending, cacheable;
  logic copro_ctrl_sel, copro_opnd_sel, mgmt_o, mgmt_oe_b, mgmt_mode, addr_strobe_b;
  logic suspend_ack_b, mgmt_enter, mgmt_addr_strobe_b;
  logic [31:0] out_addr;
  logic [1:0] bus_state;
  int fails = 0, checks_done = 0, n;
  logic [31:0] nc_a [8] = '{32'h0000_1234, 32'h0000_ffff, 32'h0010_0000, 32'h0010_ffff,
                            32'h0001_0000, 32'h000f_ffff, 32'h0011_0000, 32'h0000_1234};
  logic nc_e [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

  always #2 clock = ~clock;

  chipset_model partner (.clock(clock), .want_hold(want_hold), .want_wrap(want_wrap),
    .want_mgmt(want_mgmt), .mgmt_o(mgmt_o), .mgmt_oe_b(mgmt_oe_b), .hold_req(hold_req),
    .wrap_b(wrap_b), .mgmt_line(mgmt_line));

  cpu_sideband_control dut (.clock(clock), .rst_b(rst_b), .cfg(cfg), .wrap_mask_in_b(wrap_b),
    .hold_req(hold_req), .nmi_in(nmi_in), .lock_active(lock_active), .bus_req(bus_req),
    .cycle_done(cycle_done), .access_strobe(access_strobe), .core_addr(core_addr),
    .io_cycle(io_cycle), .mem_cycle(mem_cycle), .copro_in(copro_in),
    .mgmt_interrupt_i(mgmt_line), .mgmt_return_instr(mgmt_return_instr),
    .io_instr_done(io_instr_done), .suspend_req_b(suspend_req_b),
    .suspend_state(suspend_state), .out_addr(out_addr), .cacheable(cacheable),
    .hold_grant(hold_grant), .bus_float(bus_float), .suspend_ack_b(suspend_ack_b),
    .nmi_pending(nmi_pending),
    .copro_ctrl_sel(copro_ctrl_sel), .copro_opnd_sel(copro_opnd_sel),
    .copro_sampled(copro_sampled), .mgmt_interrupt_o(mgmt_o), .mgmt_interrupt_oe_b(mgmt_oe_b),
    .mgmt_mode(mgmt_mode), .mgmt_enter(mgmt_enter), .mgmt_addr_strobe_b(mgmt_addr_strobe_b),
    .addr_strobe_b(addr_strobe_b), .bus_state(bus_state));

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task access(input logic [31:0] a, input logic io);
    @(negedge clock);
    core_addr = a;
    io_cycle = io;
    mem_cycle = !io;
    access_strobe = 1'b1;
    @(negedge clock);
    access_strobe = 1'b0;
  endtask : access

  task wrap_test;
    cfg.wrap_mask_enable_bit = 1'b0;
    want_wrap = 1'b1;
    repeat (10) @(negedge clock);
    access(32'h0012_3456, 1'b0);
    check(out_addr, 32'h0012_3456, "mask without enable");
    cfg.wrap_mask_enable_bit = 1'b1;
    repeat (2) @(negedge clock); // Let a phase-two edge pass whatever the phase
    access(32'h0012_3456, 1'b0);
    check(out_addr, 32'h0002_3456, "masked address");
    cfg.paging_on = 1'b1;
    access(32'h0012_3456, 1'b0);
    check(out_addr, 32'h0012_3456, "paging keeps bit");
    cfg.paging_on = 1'b0;
    repeat (2) @(negedge clock);
    access(32'h0012_3456, 1'b0);
    want_wrap = 1'b0;
    repeat (10) @(negedge clock);
    check(out_addr, 32'h0002_3456, "mask persists");
    access(32'h0012_3456, 1'b0);
    check(out_addr, 32'h0012_3456, "mask lifted");
    cfg.wrap_mask_enable_bit = 1'b0;
  endtask : wrap_test

  task nocache_test;
    for (int i = 0; i < 8; i++) begin
      cfg.low_region_nocache_bit = (i < 7);
      access(nc_a[i], 1'b0);
      check(cacheable, nc_e[i], "cacheable");
    end
  endtask : nocache_test

  task copro_test;
    access(32'h8000_00f8, 1'b1);
    check({copro_ctrl_sel, copro_opnd_sel}, 2'b10, "opcode port");
    access(32'h8000_00fc, 1'b1);
    check({copro_ctrl_sel, copro_opnd_sel}, 2'b01, "operand port");
    access(32'h8000_00f4, 1'b1);
    check({copro_ctrl_sel, copro_opnd_sel}, 2'b00, "other port");
    access(32'h8000_00f8, 1'b0);
    check({copro_ctrl_sel, copro_opnd_sel}, 2'b00, "memory access");
    copro_in = 3'h5;
    repeat (8) @(negedge clock);
    check(copro_sampled, 3'h5, "coprocessor sample");
    copro_in = 3'h2;
    repeat (8) @(negedge clock);
    check(copro_sampled, 3'h2, "coprocessor sample");
  endtask : copro_test

  task hold_test(input logic pend);
    want_hold = 1'b1;
    repeat (40) if (hold_grant !== 1'b1) @(negedge clock);
    check({hold_grant, bus_float, bus_state}, 4'hf, "hold entry");
    nmi_in = 1'b1;
    repeat (6) @(negedge clock);
    check({nmi_pending, hold_grant}, 2'b11, "nmi latched in hold");
    suspend_req_b = 1'b0;
    suspend_state = 1'b1;
    @(negedge clock);
    check(suspend_ack_b, 1'b0, "suspend ack in hold");
    suspend_req_b = 1'b1;
    suspend_state = 1'b0;
    bus_req = pend;
    want_hold = 1'b0;
    repeat (40) if (hold_grant !== 1'b0) @(negedge clock);
    check(bus_state, {1'b0, pend}, "state after hold");
    if (pend) check({mgmt_addr_strobe_b, addr_strobe_b}, 2'b10, "first strobe");
    nmi_in = 1'b0;
    bus_req = 1'b0;
    cycle_done = 1'b1;
    repeat (6) @(negedge clock);
    cycle_done = 1'b0;
    check(nmi_pending, 1'b0, "interrupt 2 serviced");
  endtask : hold_test

  task lock_test;
    bus_req = 1'b1;
    lock_active = 1'b1;
    @(negedge clock);
    bus_req = 1'b0;
    want_hold = 1'b1;
    repeat (12) @(negedge clock);
    check(hold_grant, 1'b0, "no hold in locked cycle");
    lock_active = 1'b0;
    cycle_done = 1'b1;
    repeat (40) if (hold_grant !== 1'b1) @(negedge clock);
    check({hold_grant, bus_state}, 3'h7, "hold after unlocked cycle");
    cycle_done = 1'b0;
    want_hold = 1'b0;
    repeat (12) @(negedge clock);
  endtask : lock_test

  task reset_hold_test;
    want_hold = 1'b1;
    repeat (40) if (hold_grant !== 1'b1) @(negedge clock);
    rst_b = 1'b0;
    @(negedge clock);
    check(hold_grant, 1'b0, "reset ends hold");
    rst_b = 1'b1;
    repeat (40) if (hold_grant !== 1'b1) @(negedge clock);
    check({hold_grant, addr_strobe_b}, 2'b11, "hold again after reset");
    want_hold = 1'b0;
    repeat (20) @(negedge clock);
  endtask : reset_hold_test

  task mgmt_test;
    core_addr = 32'h8000_00fc;
    io_cycle = 1'b1;
    mem_cycle = 1'b0;
    want_mgmt = 1'b1;
    n = 0;
    repeat (40) if (mgmt_oe_b !== 1'b0) begin
      if (mgmt_enter === 1'b1) n++;
      @(negedge clock);
    end
    check(n, 1, "enter pulse");
    want_mgmt = 1'b0;
    repeat (5) @(negedge clock);
    check({mgmt_oe_b, mgmt_o, mgmt_mode}, 3'b001, "pin driven low");
    io_instr_done = 1'b1;
    @(posedge clock);
    check(mgmt_enter, 1'b0, "no trap on coprocessor port");
    @(negedge clock);
    core_addr = 32'h0000_00b2;
    io_instr_done = 1'b0;
    @(negedge clock);
    io_instr_done = 1'b1;
    @(posedge clock);
    check(mgmt_enter, 1'b1, "trap enters handler");
    @(negedge clock);
    io_instr_done = 1'b0;
    io_cycle = 1'b0;
    mem_cycle = 1'b1;
    bus_req = 1'b1;
    @(negedge clock);
    check({mgmt_addr_strobe_b, addr_strobe_b}, 2'b01, "management strobe");
    bus_req = 1'b0;
    cycle_done = 1'b1;
    repeat (2) @(negedge clock);
    cycle_done = 1'b0;
    mgmt_return_instr = 1'b1;
    @(negedge clock);
    mgmt_return_instr = 1'b0;
    n = 0;
    repeat (10) begin
      if (mgmt_oe_b === 1'b0 && mgmt_o === 1'b1) n++;
      @(negedge clock);
    end
    check(n, 2, "high drive cycles");
    check({mgmt_oe_b, mgmt_mode}, 2'b10, "pin released");
  endtask : mgmt_test

  task summarize;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  // Whole sequence needs well under a thousand cycles
  initial begin
    #(5000 * 4);
    fails++;
    summarize();
  end

  initial begin
    repeat (5) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    wrap_test();
    nocache_test();
    copro_test();
    hold_test(1'b0);
    hold_test(1'b1);
    lock_test();
    reset_hold_test();
    mgmt_test();
    summarize();
  end
endmodule : cpu_sideband_control_test
